// ---- logic/smcs_pkg.sv ----
// Constants and types shared by the static memory chip-select controller.
package smcs_pkg;
	localparam int NUM_CS      = 6;
	localparam int ADDR_W      = 26;
	localparam int DATA_W      = 32;
	localparam int TYPE_W      = 3;
	localparam int RRR_W       = 3;
	localparam int CODE_W      = 3;
	localparam int CNT_W       = 8;
	// Memory type field encodings.
	localparam logic [2:0] MT_ROM    = 3'h0;
	localparam logic [2:0] MT_SRAM   = 3'h1;
	localparam logic [2:0] MT_VARIABLE_LATENCY_IO   = 3'h2;
	localparam logic [2:0] MT_BURST4 = 3'h3;
	localparam logic [2:0] MT_BURST8 = 3'h4;
	// Flash read configuration fields.
	localparam int FRC_BL_LO   = 0;
	localparam int FRC_BL_HI   = 2;
	localparam int FRC_CLK     = 6;
	localparam int FRC_SEQ     = 7;
	localparam int FRC_WAIT    = 8;
	localparam int FRC_DOC     = 9;
	localparam int FRC_FRQ_LO  = 11;
	localparam int FRC_FRQ_HI  = 13;
	localparam int FRC_MODE    = 15;
	localparam logic [2:0] FRC_BL8 = 3'h2;
	// Strobe timing in core clocks and burst lengths in beats.
	localparam logic [7:0] ADV_SETUP    = 8'h01;
	localparam logic [7:0] ADV_LEN      = 8'h01;
	localparam logic [7:0] ADV_LEN_DIV2 = 8'h03;
	localparam logic [7:0] OE_ADD       = 8'h02;
	localparam logic [7:0] OE_ADD_DIV2  = 8'h04;
	localparam logic [7:0] BURST8_BEATS = 8'h08;
	localparam logic [7:0] BURST4_BEATS = 8'h04;
	localparam logic [7:0] ASYNC_ACCESS = 8'h02;
	// Access sizes.
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	typedef enum logic [2:0] {
		SMCS_IDLE, SMCS_SETUP, SMCS_ADV, SMCS_LAT, SMCS_XFER, SMCS_RECOV
	} smcs_state_e;
endpackage

// ---- logic/smcs_ctrl.sv ----
// Static memory chip-select controller with synchronous flash burst reads.
module smcs_ctrl
	import smcs_pkg::*;
#(
	parameter int N_CS = NUM_CS
) (
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	input  wire logic                    req_valid_in,
	input  wire logic                    req_write_in,
	input  wire logic [2:0]              req_cs_in,
	input  wire logic [ADDR_W-1:0]       req_addr_in,
	input  wire logic [1:0]              req_size_in,
	input  wire logic [DATA_W-1:0]       req_wdata_in,
	input  wire logic [N_CS*TYPE_W-1:0]  memory_type_field_in,
	input  wire logic [N_CS-1:0]         bus_width_field_in,
	input  wire logic [N_CS*RRR_W-1:0]   recovery_time_field_in,
	input  wire logic [15:0]             flash_read_config_in,
	input  wire logic                    clock_divide_by_two_in,
	input  wire logic                    data_ready_in,
	input  wire logic                    flash_wait_n_in,
	input  wire logic [DATA_W-1:0]       memory_data_in,
	output logic                         req_ready_out,
	output logic                         rsp_valid_out,
	output logic [DATA_W-1:0]            rsp_rdata_out,
	output logic                         rsp_last_out,
	output logic [N_CS-1:0]              chip_select_n_out,
	output logic [ADDR_W-1:0]            memory_address_out,
	output logic [DATA_W-1:0]            memory_data_out,
	output logic                         memory_data_oe_n_out,
	output logic [3:0]                   byte_mask_out,
	output logic                         address_valid_n_out,
	output logic                         output_enable_n_out,
	output logic                         write_enable_n_out,
	output logic                         io_write_strobe_n_out
);
	smcs_state_e          state;
	logic [CNT_W-1:0]     cnt;
	logic [CNT_W-1:0]     beats;
	logic [2:0]           cur_cs;
	logic [TYPE_W-1:0]    cur_type;
	logic                 cur_wr;
	logic                 cur_w16;
	logic                 cur_sync;
	logic [2:0]           rdy_sync;
	logic [2:0]           cnt_unused;

	// Only the ready strobe from the I/O device is used; flash wait never is.
	assign cnt_unused = {flash_wait_n_in, flash_read_config_in[FRC_WAIT],
		flash_read_config_in[FRC_DOC]};

	// Active-low byte enables for a write of the given size and address.
	// A 16-bit region only uses the two low lanes; the upper two stay high.
	function automatic logic [3:0] write_mask(input logic w16,
			input logic [1:0] sz, input logic [1:0] a);
		logic [3:0] m;
		m = 4'hF;
		if (w16) begin
			if (sz == SZ_BYTE)
				m = a[0] ? 4'hD : 4'hE;
			else
				m = 4'hC;
		end else begin
			unique case (sz)
				SZ_BYTE: m = ~(4'h1 << a);
				SZ_HALF: m = a[1] ? 4'h3 : 4'hC;
				default: m = 4'h0;
			endcase
		end
		return m;
	endfunction

	// Clocks from the address strobe rising to the first output enable.
	// Divide-by-two mode doubles the code before the fixed offset.
	function automatic logic [CNT_W-1:0] oe_delay(input logic div2,
			input logic [CODE_W-1:0] code);
		logic [CNT_W-1:0] c;
		c = CNT_W'(code);
		if (div2)
			return (c << 1) + OE_ADD_DIV2;
		return c + OE_ADD;
	endfunction

	// The ready input comes from a pin and is filtered by three flops.
	// A change counts only once the second and third flops agree, so a
	// glitch shorter than a clock never reaches the sequencer.
	logic rdy_ok;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdy_sync <= 3'h0;
			rdy_ok   <= 1'b0;
		end else begin
			rdy_sync <= {rdy_sync[1:0], data_ready_in};
			if (rdy_sync[1] == rdy_sync[2])
				rdy_ok <= rdy_sync[2];
		end
	end

	logic [CODE_W-1:0] frq;
	logic              sync_rd;
	assign frq = flash_read_config_in[FRC_FRQ_HI:FRC_FRQ_LO];
	// Synchronous mode needs bit 15 low, the eight-word burst code and bits 6 and 7 set.
	// Any other setting leaves the flash in its asynchronous page mode.
	assign sync_rd = !flash_read_config_in[FRC_MODE] &&
		flash_read_config_in[FRC_BL_HI:FRC_BL_LO] == FRC_BL8 &&
		flash_read_config_in[FRC_SEQ] &&
		flash_read_config_in[FRC_CLK];

	logic [TYPE_W-1:0] req_type;
	assign req_type = memory_type_field_in[req_cs_in*TYPE_W +: TYPE_W];

	// Access sequencer. One access runs at a time; a request that comes
	// while busy is not queued, so the requester holds it until its select
	// falls. A count of one ends the current phase.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state    <= SMCS_IDLE;
			cnt      <= '0;
			beats    <= '0;
			cur_cs   <= 3'h0;
			cur_type <= MT_ROM;
			cur_wr   <= 1'b0;
			cur_w16  <= 1'b0;
			cur_sync <= 1'b0;
		end else begin
			unique case (state)
				// Capture the request; its select falls on this same edge.
				SMCS_IDLE: begin
					if (req_valid_in && req_cs_in < 3'(N_CS)) begin
						cur_cs   <= req_cs_in;
						cur_type <= req_type;
						cur_wr   <= req_write_in;
						cur_w16  <= !bus_width_field_in[req_cs_in];
						// Only the lower four selects may burst synchronously.
						cur_sync <= sync_rd && !req_write_in && req_cs_in < 3'h4 &&
							(req_type == MT_BURST8 || req_type == MT_BURST4);
						cnt      <= ADV_SETUP;
						state    <= SMCS_SETUP;
					end
				end
				// One clock of address and select setup before any strobe.
				SMCS_SETUP: begin
					if (cnt <= 8'h01) begin
						if (cur_sync) begin
							cnt <= clock_divide_by_two_in ? ADV_LEN_DIV2 : ADV_LEN;
							state <= SMCS_ADV;
						end else begin
							cnt <= ASYNC_ACCESS;
							beats <= 8'h01;
							state <= SMCS_XFER;
						end
					end else
						cnt <= cnt - 8'h01;
				end
				// Address strobe low; its length depends on the divider.
				SMCS_ADV: begin
					if (cnt <= 8'h01) begin
						cnt <= oe_delay(clock_divide_by_two_in, frq);
						state <= SMCS_LAT;
					end else
						cnt <= cnt - 8'h01;
				end
				// Latency count; output enable falls as it runs out.
				SMCS_LAT: begin
					if (cnt <= 8'h01) begin
						beats <= cur_type == MT_BURST8 ? BURST8_BEATS : BURST4_BEATS;
						cnt <= 8'h01;
						state <= SMCS_XFER;
					end else
						cnt <= cnt - 8'h01;
				end
				// One beat per pass; a slow I/O device stretches the beat.
				SMCS_XFER: begin
					if (cur_type == MT_VARIABLE_LATENCY_IO && !rdy_ok)
						cnt <= cnt;
					else if (cnt <= 8'h01) begin
						if (beats <= 8'h01) begin
							cnt <= CNT_W'({recovery_time_field_in[
								cur_cs*RRR_W +: RRR_W], 1'b0});
							state <= SMCS_RECOV;
						end else begin
							beats <= beats - 8'h01;
							cnt <= cur_sync ? 8'h01 : ASYNC_ACCESS;
						end
					end else
						cnt <= cnt - 8'h01;
				end
				// Select stays high here for twice the recovery field.
				SMCS_RECOV: begin
					if (cnt <= 8'h01)
						state <= SMCS_IDLE;
					else
						cnt <= cnt - 8'h01;
				end
			endcase
		end
	end

	// A beat ends when its count runs out and the I/O device is ready.
	logic beat_end;
	assign beat_end = state == SMCS_XFER && cnt <= 8'h01 &&
		!(cur_type == MT_VARIABLE_LATENCY_IO && !rdy_ok);

	// Read strobe terms, one for each phase of an access.
	logic oe_sync_start;
	logic oe_async_start;
	logic oe_hold;
	logic oe_next_beat;
	assign oe_sync_start  = state == SMCS_LAT && cnt <= 8'h01;
	assign oe_async_start = state == SMCS_SETUP && cnt <= 8'h01 && !cur_sync;
	assign oe_hold        = state == SMCS_XFER && !beat_end;
	assign oe_next_beat   = state == SMCS_XFER && beat_end && beats > 8'h01;

	// Pin outputs, all registered.
	// The select falls on the edge that takes the request, so address and
	// select lead the address strobe by the setup clock.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			chip_select_n_out     <= '1;
			address_valid_n_out   <= 1'b1;
			output_enable_n_out   <= 1'b1;
			write_enable_n_out    <= 1'b1;
			io_write_strobe_n_out <= 1'b1;
			byte_mask_out         <= 4'h0;
			memory_address_out    <= '0;
			memory_data_out       <= '0;
			memory_data_oe_n_out  <= 1'b1;
		end else begin
			if (state == SMCS_IDLE && req_valid_in && req_cs_in < 3'(N_CS)) begin
				chip_select_n_out <= ~(N_CS'(1) << req_cs_in);
				if (req_write_in) begin
					memory_address_out <= req_addr_in;
					byte_mask_out <= write_mask(!bus_width_field_in[req_cs_in],
						req_size_in, req_addr_in[1:0]);
					memory_data_out <= req_wdata_in;
					memory_data_oe_n_out <= 1'b0;
				end else begin
					// Reads clear the low address bits below the bus width.
					memory_address_out <= bus_width_field_in[req_cs_in] ?
						{req_addr_in[ADDR_W-1:2], 2'h0} :
						{req_addr_in[ADDR_W-1:1], 1'b0};
					byte_mask_out <= 4'h0;
				end
			end else if (state == SMCS_RECOV || state == SMCS_IDLE) begin
				chip_select_n_out    <= '1;
				memory_data_oe_n_out <= 1'b1;
			end
			address_valid_n_out <= !((state == SMCS_SETUP && cnt <= 8'h01 &&
				cur_sync) || (state == SMCS_ADV && cnt > 8'h01));
			output_enable_n_out <= !(!cur_wr && (oe_sync_start ||
				oe_async_start || oe_hold || oe_next_beat));
			write_enable_n_out <= !(cur_wr && cur_type != MT_VARIABLE_LATENCY_IO &&
				state == SMCS_XFER && !beat_end);
			io_write_strobe_n_out <= !(cur_wr && cur_type == MT_VARIABLE_LATENCY_IO &&
				state == SMCS_XFER && !beat_end);
		end
	end

	// Read data returned to the requester once per beat.
	// Sixteen-bit regions return only the low half, zero extended.
	// The last flag also marks the end of a write.
	// Ready is only a hint: it is high while idle with nothing offered.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
			rsp_last_out  <= 1'b0;
			req_ready_out <= 1'b0;
		end else begin
			rsp_valid_out <= beat_end && !cur_wr;
			rsp_last_out  <= beat_end && beats <= 8'h01;
			rsp_rdata_out <= cur_w16 ? {16'h0, memory_data_in[15:0]} :
				memory_data_in;
			req_ready_out <= state == SMCS_IDLE && !req_valid_in;
		end
	end
endmodule

// ---- test/smcs_ctrl_monitor.sv ----
// Checker of select and strobe timing for the chip-select controller.
module smcs_ctrl_monitor
	import smcs_pkg::*;
#(
	parameter int N_CS = NUM_CS
) (
	input wire logic              core_clk_in,
	input wire logic              rst_in,
	input wire logic [15:0]       flash_read_config_in,
	input wire logic              clock_divide_by_two_in,
	input wire logic [N_CS-1:0]   chip_select_n_out,
	input wire logic [ADDR_W-1:0] memory_address_out,
	input wire logic [3:0]        byte_mask_out,
	input wire logic              address_valid_n_out,
	input wire logic              output_enable_n_out,
	input wire logic              write_enable_n_out,
	input wire logic              io_write_strobe_n_out
);
	logic [7:0]        gap;
	logic              armed;
	logic [CODE_W-1:0] code;
	logic [7:0]        want;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	assign code = flash_read_config_in[FRC_FRQ_HI:FRC_FRQ_LO];
	assign want = clock_divide_by_two_in ? {4'h0, code, 1'h0} + 8'h04
		: {5'h00, code} + 8'h02;
	// Clocks since the address strobe was last low, saturating.
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !address_valid_n_out)
			gap <= 8'h00;
		else if (gap != 8'hFF)
			gap <= gap + 8'h01;
	end
	// Set by a strobed access until its first output enable.
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !output_enable_n_out)
			armed <= 1'b0;
		else if (!address_valid_n_out)
			armed <= 1'b1;
	end
	one_select_a: assert property ($onehot0(~chip_select_n_out))
		else $error("more than one chip select low");
	strobe_in_select_a: assert property (!(output_enable_n_out
		&& write_enable_n_out && io_write_strobe_n_out
		&& address_valid_n_out) |-> !(&chip_select_n_out))
		else $error("strobe active without a chip select");
	read_zero_a: assert property (!output_enable_n_out
		|-> byte_mask_out == 4'h0 && memory_address_out[0] == 1'b0)
		else $error("read with nonzero mask or low address");
	write_apart_a: assert property (!output_enable_n_out
		|-> write_enable_n_out && io_write_strobe_n_out)
		else $error("write strobe during read");
	strobe_pair_a: assert property (!write_enable_n_out
		|-> io_write_strobe_n_out)
		else $error("both write strobes low");
	adv_setup_a: assert property ($fell(address_valid_n_out)
		|-> !(&$past(chip_select_n_out)))
		else $error("address strobe without select setup");
	adv_one_a: assert property ($fell(address_valid_n_out)
		&& !clock_divide_by_two_in |=> address_valid_n_out)
		else $error("address strobe not one clock");
	adv_three_a: assert property ($fell(address_valid_n_out)
		&& clock_divide_by_two_in
		|-> !address_valid_n_out [*3] ##1 address_valid_n_out)
		else $error("address strobe not three clocks");
	oe_latency_a: assert property ($fell(output_enable_n_out)
		&& armed |-> gap == want)
		else $error("output enable latency wrong");
endmodule

bind smcs_ctrl smcs_ctrl_monitor #(.N_CS(N_CS)) i_mon (.core_clk_in,
	.rst_in, .flash_read_config_in, .clock_divide_by_two_in,
	.chip_select_n_out, .memory_address_out, .byte_mask_out,
	.address_valid_n_out, .output_enable_n_out, .write_enable_n_out,
	.io_write_strobe_n_out);

// ---- test/smcs_mem_model.sv ----
// Behavioural flash, SRAM and slow I/O device on the memory bus.
module smcs_mem_model
	import smcs_pkg::*;
(
	input  wire logic [5:0]        chip_select_n_in,
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] memory_address_in,
	input  wire logic              address_valid_n_in,
	input  wire logic              output_enable_n_in,
	input  wire logic [7:0]        stall_in,
	output logic [DATA_W-1:0]      memory_data_out,
	output logic                   data_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] base;
	logic [7:0]        beat;
	logic [7:0]        wait_cnt;
	logic              sync_acc;
	logic [DATA_W-1:0] last;
	always_ff @(posedge core_clk_in) begin
		if (!address_valid_n_in)
			base <= memory_address_in;
		sync_acc <= !rst_in && (!address_valid_n_in
			|| (sync_acc && !(&chip_select_n_in)));
		beat <= output_enable_n_in ? 8'h00 : beat + 8'h01;
		wait_cnt <= &chip_select_n_in ? 8'h00
			: wait_cnt + {7'h00, wait_cnt != 8'hFF};
		last <= rst_in ? '0 : memory_data_out;
	end
	// Undriven bus toggles so a late sample never looks right.
	assign memory_data_out = output_enable_n_in ? ~last
		: {6'h00, sync_acc ? base + {16'h0000, beat, 2'h0}
		: memory_address_in};
	assign data_ready_out = stall_in == 8'h00 || wait_cnt >= stall_in;
endmodule

// ---- test/static_memory_chip_select_ctrl_bench.sv ----
// Self-checking bench for the static memory chip-select controller.
module static_memory_chip_select_ctrl_bench
	import smcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in, rst_in, req_valid_in, req_write_in, data_ready_in;
	logic clock_divide_by_two_in, flash_wait_n_in, req_ready_out;
	logic rsp_valid_out, rsp_last_out, memory_data_oe_n_out;
	logic address_valid_n_out, output_enable_n_out, write_enable_n_out;
	logic io_write_strobe_n_out, oe_w;
	logic [2:0] req_cs_in;
	logic [1:0] req_size_in;
	logic [25:0] req_addr_in, memory_address_out, addr_w;
	logic [31:0] req_wdata_in, memory_data_in, rsp_rdata_out;
	logic [31:0] memory_data_out, data_w;
	logic [17:0] memory_type_field_in, recovery_time_field_in;
	logic [5:0] bus_width_field_in, chip_select_n_out;
	logic [15:0] flash_read_config_in;
	logic [3:0] byte_mask_out, mask_w;
	logic [7:0] stall;
	logic [31:0] data_q[$];
	int err_count, num_checks, gap, we_cyc, pwe_cyc;
	smcs_ctrl i_dut (.*);
	smcs_mem_model i_mem (.core_clk_in, .rst_in, .stall_in(stall),
		.chip_select_n_in(chip_select_n_out),
		.memory_address_in(memory_address_out),
		.address_valid_n_in(address_valid_n_out),
		.output_enable_n_in(output_enable_n_out),
		.memory_data_out(memory_data_in), .data_ready_out(data_ready_in));
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Holds one request until its select falls, then records the access.
	task automatic issue(input logic [2:0] c, input logic w,
		input logic [25:0] a, input logic [1:0] s);
		int n;
		@(negedge core_clk_in);
		req_valid_in = 1'b1;
		req_write_in = w;
		req_cs_in = c;
		req_addr_in = a;
		req_size_in = s;
		req_wdata_in = {6'h00, a};
		for (gap = 0; &chip_select_n_out && gap < 300; gap++)
			@(negedge core_clk_in);
		req_valid_in = 1'b0;
		addr_w = memory_address_out;
		data_q = {};
		we_cyc = 0;
		pwe_cyc = 0;
		data_w = '0;
		oe_w = 1'b1;
		for (n = 0; n < 300 && rsp_last_out !== 1'b1; n++) begin
			@(negedge core_clk_in);
			if (rsp_valid_out === 1'b1)
				data_q.push_back(rsp_rdata_out);
			if (write_enable_n_out === 1'b0) begin
				mask_w = byte_mask_out;
				data_w = memory_data_out;
				oe_w = memory_data_oe_n_out;
			end
			we_cyc += int'(write_enable_n_out === 1'b0);
			pwe_cyc += int'(io_write_strobe_n_out === 1'b0);
		end
		chk("access done", 1, n < 300);
	endtask
	task automatic t_writes();
		logic [15:0] tbl[10] = '{16'h100E, 16'h101D, 16'h102B, 16'h1037,
			16'h110C, 16'h1123, 16'h1200, 16'h0002, 16'h0011, 16'h0100};
		logic [25:0] a;
		@(negedge core_clk_in);
		chk("ready idle", 1, req_ready_out);
		for (int i = 0; i < 10; i++) begin
			a = 26'h2ABCD00 | {20'h0, tbl[i][5:4]};
			issue(tbl[i][12] ? 3'h1 : 3'h2, 1'b1, a, tbl[i][9:8]);
			chk("write mask", tbl[i][3:0], tbl[i][12] ? mask_w
				: {2'h0, mask_w[1:0]});
			chk("write address", a, addr_w);
			chk("write data", {6'h00, a}, data_w);
			chk("data drive", 0, oe_w);
			chk("write strobe", 1, we_cyc > 0 && pwe_cyc == 0);
			if (i > 0 && i < 8)
				chk("recovery gap", 1, gap >= 4);
		end
		$display("test writes done");
	endtask
	task automatic t_variable_latency_io();
		int base;
		issue(3'h3, 1'b1, 26'h40, SZ_WORD);
		base = pwe_cyc;
		chk("io strobe", 1, base > 0 && we_cyc == 0);
		stall = 8'h08;
		issue(3'h3, 1'b1, 26'h40, SZ_WORD);
		chk("io wait", 1, pwe_cyc >= base + 4);
		stall = 8'h00;
		$display("test io done");
	endtask
	task automatic t_reads();
		int beats[5] = '{1, 1, 1, 4, 8};
		flash_read_config_in = 16'h18C2;
		flash_wait_n_in = 1'b0;
		for (int d = 0; d < 2; d++)
			for (int t = 0; t < 5; t++) begin
				memory_type_field_in[2:0] = 3'(t);
				clock_divide_by_two_in = d[0];
				issue(3'h0, 1'b0, 26'h1002, SZ_WORD);
				chk("beats", beats[t], data_q.size());
				for (int k = 1; k < data_q.size(); k++)
					chk("linear", data_q[k-1] + 4, data_q[k]);
				if (t < 3)
					chk("read data", 32'h1000, data_q[0]);
			end
		issue(3'h2, 1'b0, 26'h2345, SZ_BYTE);
		chk("narrow read", 16'h2344, data_q[0][15:0]);
		$display("test reads done");
	endtask
	initial begin
		rst_in = 1'b1;
		{req_valid_in, req_write_in, req_cs_in, req_addr_in} = '0;
		{req_size_in, req_wdata_in, clock_divide_by_two_in, stall} = '0;
		memory_type_field_in = {6'h00, MT_VARIABLE_LATENCY_IO, MT_SRAM, MT_SRAM, MT_ROM};
		bus_width_field_in = 6'h3B;
		recovery_time_field_in = 18'h00010;
		flash_read_config_in = 16'h8000;
		flash_wait_n_in = 1'b1;
		repeat (5) @(negedge core_clk_in);
		rst_in = 1'b0;
		t_writes();
		t_variable_latency_io();
		t_reads();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge core_clk_in);
		err_count++;
		final_report();
	end
endmodule
